// [inc/pxc_pkg.sv]
// package for the port configuration and crossbar gate block
package pxc_pkg;
	localparam int NUM_BANK_PINS = 8;                 // pins in each of ports 0 and 1
	localparam int NUM_PORT2_PINS = 2;                // pins in port 2
	localparam logic [7:0] INPUT_MODE_RESET = 8'hff;  // all digital inputs
	localparam logic [7:0] OUTPUT_MODE_RESET = 8'h00; // open-drain
	localparam logic [7:0] SKIP_RESET = 8'h00;
	localparam logic [7:0] XBAR_SEL_RESET = 8'h00;
	localparam logic [2:0] DRIVE_RESET = 3'h0;        // low drive strength per bank
	localparam int XBAR_ENABLE_BIT = 6;               // enable bit in third select reg
	localparam int WEAK_PULLUP_DISABLE_BIT = 7;                   // pull-up disable bit in second select reg
	localparam int DEBUG_PIN_INDEX = 0;               // port 2 pin shared with debug data
	typedef enum logic [1:0] {
		PXC_MODE_GPIO   = 2'b00,
		PXC_MODE_PERIPH = 2'b01,
		PXC_MODE_ANALOG = 2'b10
	} pxc_pin_use_t;
endpackage : pxc_pkg

// [rtl/pxc_port_config.sv]
// port pin configuration registers and crossbar output gate
// Function
// - ports 0,1 pins: GPIO, peripheral or analog
// - port 2 GPIO or analog, no peripheral; pin 0 shares debug
// - latch read returns pin state, zero on analog pins
// - per-pin push-pull or open-drain select
// - per-bank drive strength select
// - input mode one digital, zero analog
// - analog pin: no pull-up, driver, receiver
// - reset makes every pin a digital input
// - peripheral outputs use programmed output mode
// - serial bus pins always open-drain
// - pull-up on open-drain unless disable bit
// - pull-up off while pin drives low
// - crossbar enable bit in third select
// - disabled crossbar keeps pins as inputs
// - disabled crossbar disables all output drivers
// - skipped pins passed over by assignment
`timescale 1ns/1ps
module pxc_port_config #(
	parameter int NPINS = 18 // ports 0, 1 and 2 together
) (
	input  wire logic             ref_clk_in,
	input  wire logic             rstn_in,
	// software write port: select, data and strobe
	input  wire logic [3:0]       wr_sel_in,     // 0..2 in mode,3..5 out mode,6..8 skip,9..11 xbar,12 drv
	input  wire logic [7:0]       wr_data_in,
	input  wire logic             wr_en_in,
	input  wire logic [3:0]       rd_sel_in,
	output logic      [7:0]       rd_data_out,
	// per-pin routing from the crossbar decoder
	input  wire logic [NPINS-1:0] periph_sel_in,   // pin claimed by a peripheral
	input  wire logic [NPINS-1:0] periph_out_in,   // peripheral output level
	input  wire logic [NPINS-1:0] smbus_pin_in,    // pin carries serial bus data or clock
	input  wire logic [NPINS-1:0] gpio_out_in,     // port latch output level
	// pad side
	input  wire logic [NPINS-1:0] pad_in,
	output logic      [NPINS-1:0] pad_out,
	output logic      [NPINS-1:0] pad_oe_out,
	output logic      [NPINS-1:0] pad_pullup_out,
	output logic      [NPINS-1:0] pad_rx_en_out,
	output logic      [2:0]       bank_drive_out,
	output logic      [NPINS-1:0] pin_state_out,   // synchronised level for port latch reads
	output logic                  crossbar_global_enable_out,
	output logic      [NPINS-1:0] skip_mask_out
);
	logic [NPINS-1:0] port_input_mode_reg;
	logic [NPINS-1:0] port_output_mode_reg;
	logic [NPINS-1:0] port_skip_reg;
	logic [7:0]       crossbar_select_first;
	logic [7:0]       crossbar_select_second;
	logic [7:0]       crossbar_select_third;
	logic [2:0]       drive_reg;
	logic [NPINS-1:0] pad_meta;
	logic [NPINS-1:0] pad_sync;
	logic [NPINS-1:0] next_pad_out;
	logic [NPINS-1:0] next_pad_oe;
	logic [NPINS-1:0] next_pullup;
	logic [NPINS-1:0] next_rx_en;
	logic [NPINS-1:0] per_od;      // peripheral pin carrying the serial bus
	wire              xbar_on = crossbar_select_third[pxc_pkg::XBAR_ENABLE_BIT];
	wire              weak_pullup_disable = crossbar_select_second[pxc_pkg::WEAK_PULLUP_DISABLE_BIT];

	// register writes, taken on the next edge
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			port_input_mode_reg    <= {NPINS{1'b1}};
			port_output_mode_reg   <= '0;
			port_skip_reg          <= '0;
			crossbar_select_first  <= pxc_pkg::XBAR_SEL_RESET;
			crossbar_select_second <= pxc_pkg::XBAR_SEL_RESET;
			crossbar_select_third  <= pxc_pkg::XBAR_SEL_RESET;
			drive_reg              <= pxc_pkg::DRIVE_RESET;
		end else if (wr_en_in) begin
			case (wr_sel_in)
				4'h0: port_input_mode_reg[7:0]   <= wr_data_in;
				4'h1: port_input_mode_reg[15:8]  <= wr_data_in;
				4'h2: port_input_mode_reg[17:16] <= wr_data_in[1:0];
				4'h3: port_output_mode_reg[7:0]  <= wr_data_in;
				4'h4: port_output_mode_reg[15:8] <= wr_data_in;
				4'h5: port_output_mode_reg[17:16] <= wr_data_in[1:0];
				4'h6: port_skip_reg[7:0]         <= wr_data_in;
				4'h7: port_skip_reg[15:8]        <= wr_data_in;
				4'h8: port_skip_reg[17:16]       <= wr_data_in[1:0];
				4'h9: crossbar_select_first      <= wr_data_in;
				4'ha: crossbar_select_second     <= wr_data_in;
				4'hb: crossbar_select_third      <= wr_data_in;
				4'hc: drive_reg                  <= wr_data_in[2:0];
				default: ;
			endcase
		end
	end

	// register reads, no side effects
	always_comb begin
		case (rd_sel_in)
			4'h0: rd_data_out = port_input_mode_reg[7:0];
			4'h1: rd_data_out = port_input_mode_reg[15:8];
			4'h2: rd_data_out = {6'h00, port_input_mode_reg[17:16]};
			4'h3: rd_data_out = port_output_mode_reg[7:0];
			4'h4: rd_data_out = port_output_mode_reg[15:8];
			4'h5: rd_data_out = {6'h00, port_output_mode_reg[17:16]};
			4'h6: rd_data_out = port_skip_reg[7:0];
			4'h7: rd_data_out = port_skip_reg[15:8];
			4'h8: rd_data_out = {6'h00, port_skip_reg[17:16]};
			4'h9: rd_data_out = crossbar_select_first;
			4'ha: rd_data_out = crossbar_select_second;
			4'hb: rd_data_out = crossbar_select_third;
			4'hc: rd_data_out = {5'h00, drive_reg};
			4'hd: rd_data_out = pin_state_out[7:0];   // port latch 0
			4'he: rd_data_out = pin_state_out[15:8];  // port latch 1
			4'hf: rd_data_out = {6'h00, pin_state_out[17:16]};
			default: rd_data_out = 8'h00;
		endcase
	end

	// per-pin driver decode
	genvar i;
	generate
		for (i = 0; i < NPINS; i++) begin : g_pin
			// port 2 pins never take a peripheral
			wire per = (i < 16) ? periph_sel_in[i] : 1'b0;
			wire lvl = per ? periph_out_in[i] : gpio_out_in[i];
			wire dig = port_input_mode_reg[i];
			wire od  = per_od[i] || !port_output_mode_reg[i];
			wire drv = xbar_on && dig && (!od || !lvl);
			assign per_od[i]       = per && smbus_pin_in[i];
			assign next_pad_out[i] = lvl;
			assign next_pad_oe[i]  = drv;
			assign next_pullup[i]  = dig && od && !weak_pullup_disable
				&& !(xbar_on && !lvl);
			assign next_rx_en[i]   = dig;
		end
	endgenerate

	// pad outputs registered; pad input synchronised
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			pad_out        <= '0;
			pad_oe_out     <= '0;
			pad_pullup_out <= '0;
			pad_rx_en_out  <= '1;
			pad_meta       <= '0;
			pad_sync       <= '0;
		end else begin
			pad_out        <= next_pad_out;
			pad_oe_out     <= next_pad_oe;
			pad_pullup_out <= next_pullup;
			pad_rx_en_out  <= next_rx_en;
			pad_meta       <= pad_in;
			pad_sync       <= pad_meta;
		end
	end

	assign pin_state_out = pad_sync & port_input_mode_reg;
	assign bank_drive_out = drive_reg;
	assign crossbar_global_enable_out = xbar_on;
	assign skip_mask_out = port_skip_reg;

	// assertions
	no_drive_off_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		!$past(xbar_on) |-> pad_oe_out == '0) else $error("driver on with crossbar off");
	analog_quiet_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		((pad_oe_out | pad_pullup_out | pad_rx_en_out) & ~$past(port_input_mode_reg)) == '0)
		else $error("analog pin active");
	low_nopull_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(pad_pullup_out & pad_oe_out & ~pad_out) == '0) else $error("pull-up on low");
	reset_in_a: assert property (@(posedge ref_clk_in) !rstn_in |=> port_input_mode_reg == '1)
		else $error("reset not digital input");
	write_next_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		wr_en_in && wr_sel_in == 4'h9 |=> crossbar_select_first == $past(wr_data_in))
		else $error("write not applied");
	smb_od_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(pad_oe_out & pad_out & $past(per_od)) == '0)
		else $error("bus pin drove high");
	wpud_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		$past(weak_pullup_disable) |-> pad_pullup_out == '0) else $error("pull-up disabled");
	pp_pull_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(pad_pullup_out & $past(port_output_mode_reg & ~per_od)) == '0)
		else $error("pull-up on push-pull");

	// receivers follow the input mode one edge later
	rx_digital_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		pad_rx_en_out == $past(port_input_mode_reg)) else $error("receiver enable wrong");
	// port 2 always follows its latch, never a peripheral
	p2_gpio_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		$past(rstn_in) |-> pad_out[17:16] == $past(gpio_out_in[17:16]))
		else $error("port 2 level not from latch");
	// push-pull digital pins drive whenever the crossbar is on
	pp_drive_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		$past(rstn_in && xbar_on)
		|-> (~pad_oe_out & $past(port_input_mode_reg & port_output_mode_reg & ~per_od)) == '0)
		else $error("push-pull pin not driven");
	// open-drain digital pins keep the pull-up while the crossbar is off and the pull-up disable bit is clear
	pull_od_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		$past(rstn_in && !weak_pullup_disable && !xbar_on)
		|-> pad_pullup_out == $past(port_input_mode_reg & ~(port_output_mode_reg & ~per_od)))
		else $error("pull-up missing on open-drain pin");
	// reset leaves every pad undriven and without pull-up
	reset_out_a: assert property (@(posedge ref_clk_in) !rstn_in |=>
		(pad_oe_out == '0) && (pad_pullup_out == '0)) else $error("pad active after reset");
	// drive strength and skip writes land on the next edge
	drive_write_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		wr_en_in && wr_sel_in == 4'hc |=> bank_drive_out == $past(wr_data_in[2:0]))
		else $error("drive write not applied");
	skip_write_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		wr_en_in && wr_sel_in == 4'h6 |=> skip_mask_out[7:0] == $past(wr_data_in))
		else $error("skip write not applied");
	// crossbar enable writes, as steps: write, register; on a clear also the pad drivers
	sequence xbar_set_s;
		wr_en_in && wr_sel_in == 4'hb && wr_data_in[pxc_pkg::XBAR_ENABLE_BIT];
	endsequence
	sequence xbar_clr_s;
		wr_en_in && wr_sel_in == 4'hb && !wr_data_in[pxc_pkg::XBAR_ENABLE_BIT];
	endsequence
	xbar_set_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		xbar_set_s |=> xbar_on) else $error("crossbar not enabled");
	xbar_clear_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		xbar_clr_s |=> !xbar_on ##1 pad_oe_out == '0) else $error("drivers on after disable");
endmodule : pxc_port_config

// [testbench/pxc_pad_model.sv]
// external circuit model on the port pads
`timescale 1ns/1ps
module pxc_pad_model (
	input  wire logic        clk_in,
	input  wire logic [17:0] pad_out_in,
	input  wire logic [17:0] oe_in,
	input  wire logic [17:0] pullup_in,
	input  wire logic [17:0] ext_drv_in,
	input  wire logic [17:0] ext_val_in,
	output logic      [17:0] pad_in_out
);
	logic [17:0] lvl;
	logic [17:0] lvl_q = 18'h0;
	// pad driver wins, then the outside driver, then pull-up; a floating pad keeps toggling
	assign lvl = (oe_in & pad_out_in) | (~oe_in & ext_drv_in & ext_val_in)
		| (~oe_in & ~ext_drv_in & (pullup_in | ~lvl_q));
	assign pad_in_out = lvl_q;
	// pad level settles one cycle after the drivers change
	always @(posedge clk_in) begin
		lvl_q <= lvl;
	end
endmodule : pxc_pad_model

// [testbench/tb_top.sv]
// self-checking testbench for the port configuration block
`timescale 1ns/1ps
module tb_top;
	logic        ref_clk_in = 0, rstn_in = 0, wr_en = 0, chk = 0, xe;
	logic [3:0]  wr_sel = 0, rd_sel = 0;
	logic [7:0]  wr_data = 0, rd_data, r;
	logic [17:0] psel = 0, pout = 0, smb = 0, gout = 0, ext = 0, xv = 0;
	logic [17:0] pad_i, pad_o, oe, pu, rx, pst, skip;
	logic [2:0]  drv;
	logic [20:0] e;
	logic [20:0] q[$];
	int          errors = 0, n_tests = 0, cyc = 0;
	always #2.5 ref_clk_in = ~ref_clk_in;
	pxc_port_config u_pxc_port_config (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
		.wr_sel_in(wr_sel), .wr_data_in(wr_data), .wr_en_in(wr_en), .rd_sel_in(rd_sel),
		.rd_data_out(rd_data), .periph_sel_in(psel), .periph_out_in(pout), .smbus_pin_in(smb),
		.gpio_out_in(gout), .pad_in(pad_i), .pad_out(pad_o), .pad_oe_out(oe),
		.pad_pullup_out(pu), .pad_rx_en_out(rx), .bank_drive_out(drv), .pin_state_out(pst),
		.crossbar_global_enable_out(xe), .skip_mask_out(skip));
	pxc_pad_model u_pxc_pad_model (.clk_in(ref_clk_in), .pad_out_in(pad_o), .oe_in(oe),
		.pullup_in(pu), .ext_drv_in(ext), .ext_val_in(xv), .pad_in_out(pad_i));
	// one software write, strobe high for exactly one edge
	task automatic wr(input logic [3:0] s, input logic [7:0] d);
		@(posedge ref_clk_in) begin
			wr_sel <= s;
			wr_data <= d;
			wr_en <= 1'b1;
		end
		@(posedge ref_clk_in) wr_en <= 1'b0;
	endtask : wr
	// note an expected value after n edges and flag the watcher
	task automatic ex(input logic [2:0] k, input logic [17:0] v, input int n = 2);
		repeat (n) @(posedge ref_clk_in);
		q.push_back({k, v});
		chk <= 1'b1;
		@(posedge ref_clk_in) chk <= 1'b0;
	endtask : ex
	function automatic logic [17:0] obs(input logic [2:0] k);
		case (k)
			3'h0: return oe;
			3'h1: return pu;
			3'h2: return rx;
			3'h3: return {10'h0, rd_data};
			3'h4: return skip;
			default: return {14'h0, xe, drv};
		endcase
	endfunction : obs
	task end_of_test;
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : end_of_test
	// watcher: compare the oldest note with the settled outputs
	always @(negedge ref_clk_in) begin
		if (chk) begin
			e = q.pop_front();
			n_tests++;
			if (obs(e[20:18]) !== e[17:0]) begin
				errors++;
				$display("[ERR] t=%0t exp=%h got=%h", $time, e[17:0], obs(e[20:18]));
			end
		end
	end
	// hang guard
	always @(posedge ref_clk_in) begin
		cyc++;
		if (cyc == 2000) begin
			errors++;
			end_of_test();
		end
	end
	initial begin
		void'($urandom(32'h4c4b));
		repeat (12) @(posedge ref_clk_in);
		rstn_in <= 1'b1;
		gout <= {10'h3ff, 8'($urandom)};
		ex(3'h0, 18'h0);
		ex(3'h2, 18'h3ffff);
		wr(4'h3, 8'hff);
		wr(4'hb, 8'hbf);
		ex(3'h0, 18'h0);
		wr(4'hb, 8'h40);
		ex(3'h0, 18'h000ff);
		ex(3'h1, 18'h3ff00);
		gout <= {10'h300, 8'($urandom)};
		ex(3'h0, 18'h0ffff);
		ex(3'h1, 18'h30000);
		wr(4'ha, 8'h80);
		ex(3'h1, 18'h0);
		wr(4'h0, 8'hf0);
		ex(3'h0, 18'h0fff0);
		ex(3'h2, 18'h3fff0);
		psel <= 18'h30;
		smb <= 18'h10;
		pout <= 18'h30;
		ex(3'h0, 18'h0ffe0);
		wr(4'h6, 8'h0f);
		ex(3'h4, 18'h0000f);
		wr(4'hc, 8'h05);
		ex(3'h5, 18'h0000d);
		rd_sel <= 4'h6;
		ex(3'h3, 18'h0000f);
		r = 8'($urandom);
		ext <= 18'h30000;
		xv <= {r[1:0], 16'h0};
		rd_sel <= 4'hf;
		ex(3'h3, {16'h0, r[1:0]}, 5);
		rstn_in <= 1'b0;
		ex(3'h2, 18'h3ffff);
		ex(3'h0, 18'h0);
		rstn_in <= 1'b1;
		ex(3'h1, 18'h3ffff);
		ex(3'h5, 18'h0);
		end_of_test();
	end
endmodule : tb_top
